// ==== common/phc_map.vh ====
// constants for the pll holdover controller
`ifndef PHC_MAP_VH
`define PHC_MAP_VH

// lock detect counter codes and the cycle counts they select
`define PHC_LDC_W 2
`define PHC_LDC_5 2'h0
`define PHC_LDC_16 2'h1
`define PHC_LDC_64 2'h2
`define PHC_LDC_255 2'h3
`define PHC_CNT_W 8
`define PHC_LOCK_CYC_5 8'h05
`define PHC_LOCK_CYC_16 8'h10
`define PHC_LOCK_CYC_64 8'h40
`define PHC_LOCK_CYC_255 8'hff

// lock indicator pin output select
`define PHC_LDSEL_W 6
`define PHC_LDSEL_DLD_HI 6'h01
`define PHC_LDSEL_DLD_LO 6'h02
`define PHC_LDSEL_CSRC 6'h04

// reference monitor pin select, low five bits decoded
`define PHC_MON_W 5
`define PHC_MON_GND 5'h00
`define PHC_MON_DLD_HI 5'h03
`define PHC_MON_CMP_HI 5'h0c
`define PHC_MON_DLD_LO 5'h13
`define PHC_MON_CMP_LO 5'h1c
`define PHC_MON_FIRST_REFERENCE_LO 5'h17

// status pin select
`define PHC_STS_W 6
`define PHC_STS_GND 6'h00
`define PHC_STS_DLD_HI 6'h01
`define PHC_STS_CMP_HI 6'h0c
`define PHC_STS_DLD_LO 6'h21
`define PHC_STS_CMP_LO 6'h2c
`define PHC_STS_FIRST_REFERENCE_LO 6'h37

// reset values of control state
`define PHC_RST_TRIG 1'b1
`define PHC_RST_ARMED 1'b1
`define PHC_RST_HOLD 1'b0

`endif

// ==== design/phc_dld.v ====
// digital lock indicator: consecutive phase detector cycle counter
`timescale 1ns/1ps
`include "phc_map.vh"

module phc_dld #(
    parameter CNT_W = 8
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // configuration
    input wire disable_i,
    input wire [1:0] cnt_sel_i,
    // phase detector cycle results
    input wire pfd_event_i,
    input wire err_below_lock_i,
    input wire err_above_unlock_i,
    // indicator
    output reg locked_o
);

reg [CNT_W-1:0] good_cnt;
reg [CNT_W-1:0] need_cnt;

always @* begin
    case (cnt_sel_i)
        `PHC_LDC_5: need_cnt = `PHC_LOCK_CYC_5;
        `PHC_LDC_16: need_cnt = `PHC_LOCK_CYC_16;
        `PHC_LDC_64: need_cnt = `PHC_LOCK_CYC_64;
        default: need_cnt = `PHC_LOCK_CYC_255;
    endcase
end

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        good_cnt <= {CNT_W{1'b0}};
        locked_o <= 1'b0;
    end else if (disable_i) begin
        good_cnt <= {CNT_W{1'b0}};
        locked_o <= 1'b0;
    end else if (pfd_event_i) begin
        if (err_above_unlock_i) begin
            // one wide-error cycle drops lock at once
            good_cnt <= {CNT_W{1'b0}};
            locked_o <= 1'b0;
        end else if (err_below_lock_i) begin
            if (good_cnt + 1'b1 >= need_cnt) begin
                locked_o <= 1'b1;
            end
            if (good_cnt != need_cnt) begin
                good_cnt <= good_cnt + 1'b1;
            end
        end else if (!locked_o) begin
            // between thresholds: no progress toward lock
            good_cnt <= {CNT_W{1'b0}};
        end
    end
end

endmodule

// ==== design/phc_stat_mux.v ====
// status routing mux for the monitor and status pins
`timescale 1ns/1ps
`include "phc_map.vh"

module phc_stat_mux #(
    parameter SEL_W = 5,
    parameter [SEL_W-1:0] CODE_DLD_HI = 0,
    parameter [SEL_W-1:0] CODE_DLD_LO = 0,
    parameter [SEL_W-1:0] CODE_CMP_HI = 0,
    parameter [SEL_W-1:0] CODE_CMP_LO = 0,
    parameter [SEL_W-1:0] CODE_FIRST_REFERENCE_LO = 0
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // selection and sources
    input wire [SEL_W-1:0] sel_i,
    input wire dld_i,
    input wire cmp_i,
    input wire first_reference_ok_i,
    // pin level
    output reg pin_o
);

reg next_pin;

always @* begin
    if (sel_i == CODE_DLD_HI) begin
        next_pin = dld_i;
    end else if (sel_i == CODE_DLD_LO) begin
        next_pin = ~dld_i;
    end else if (sel_i == CODE_CMP_HI) begin
        next_pin = cmp_i;
    end else if (sel_i == CODE_CMP_LO) begin
        next_pin = ~cmp_i;
    end else if (sel_i == CODE_FIRST_REFERENCE_LO) begin
        next_pin = ~first_reference_ok_i;
    end else begin
        next_pin = 1'b0;
    end
end

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        pin_o <= 1'b0;
    end else begin
        pin_o <= next_pin;
    end
end

endmodule

// ==== design/phc_top.v ====
// pll holdover controller: charge pump freeze, release and lock detect routing
// Functional notes
// - holdover acts only when both enable bits are set
// - manual mode: trigger pin falling edge freezes charge pump at once
// - after trigger returns high, release only on next reference edge
// - release resets feedback main counter; prescaler keeps running
// - external control bit: 0 automatic on lock loss, 1 manual pin
// - automatic mode: low lock pin level freezes charge pump
// - comparator off makes lock pin read as always high
// - automatic holdover stays until a reference edge arrives
// - no automatic re-entry until relocked and lock pin high again
// - holdover follows the selected reference's edges
// - lock counter code 00 means five consecutive cycles
// - automatic holdover unusable while lock indicator disabled
// - lock pin select code 000100 picks current source mode
// - current source mode: source while locked, short when not
// - comparator routable to monitor and status pins, both polarities
// - window bit 0 selects the high range window
// - monitor code 0xf7 gives first reference active low; 11 enables buffers
// - lock after counted good cycles, lost on one wide-error cycle
`timescale 1ns/1ps
`include "phc_map.vh"

module phc_top #(
    parameter CNT_W = 8
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // holdover control bits
    input wire hold_en0_i,
    input wire hold_en2_i,
    input wire ext_hold_i,
    input wire ld_cmp_en_i,
    // lock detect configuration
    input wire [1:0] ld_cnt_sel_i,
    input wire ld_window_i,
    input wire dld_disable_i,
    input wire [5:0] ld_out_sel_i,
    // pin routing configuration
    input wire [7:0] reference_monitor_pin_sel_i,
    input wire [5:0] status_sel_i,
    input wire [1:0] ref_buf_sel_i,
    input wire ref_sel_i,
    // trigger pin, active low
    input wire hold_trig_n_i,
    // phase detector events per reference
    input wire first_reference_edge_i,
    input wire second_reference_edge_i,
    input wire err_below_lock_i,
    input wire err_above_unlock_i,
    // reference status and lock pin comparator
    input wire first_reference_ok_i,
    input wire ld_cmp_i,
    // charge pump and divider control
    output wire charge_pump_hiz_o,
    output reg main_cnt_reset_o,
    output reg holdover_active_o,
    // lock indicator pin drive
    output reg ld_pin_o,
    output reg ld_pin_oe_o,
    output reg ld_src_en_o,
    output reg ld_short_o,
    // analog and status side
    output reg window_high_o,
    output reg first_reference_buf_en_o,
    output reg second_reference_buf_en_o,
    output wire dld_locked_o,
    output wire reference_monitor_pin_pin_o,
    output wire status_pin_o
);

////////////////////////////////////////////////////////////////////////
// lock indicator and lock pin sensing

wire dld_locked;
wire hold_en;
wire lock_level;
wire ref_edge;

phc_dld #(
    .CNT_W(CNT_W)
) u_dld (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .disable_i(dld_disable_i),
    .cnt_sel_i(ld_cnt_sel_i),
    .pfd_event_i(ref_edge),
    .err_below_lock_i(err_below_lock_i),
    .err_above_unlock_i(err_above_unlock_i),
    .locked_o(dld_locked)
);

assign dld_locked_o = dld_locked;

assign hold_en = hold_en0_i & hold_en2_i;

// disabled comparator reads as a charged pin, so auto entry never fires
assign lock_level = ld_cmp_en_i ? ld_cmp_i : 1'b1;

// only the selected reference's edge counts as a release event
assign ref_edge = ref_sel_i ? second_reference_edge_i : first_reference_edge_i;

////////////////////////////////////////////////////////////////////////
// holdover entry and release

reg trig_prev;
reg hold_flag;
reg armed;
wire manual_edge;
wire auto_entry;
wire entry;
wire release_ok;
wire release_pulse;

// edge only: a pin parked low does not re-enter after release
assign manual_edge = trig_prev & ~hold_trig_n_i;

assign auto_entry = armed & ~lock_level & ~dld_disable_i;

assign entry = hold_en & ~hold_flag &
    (ext_hold_i ? manual_edge : auto_entry);

// manual release waits for the pin high; both wait for a reference edge
assign release_ok = ext_hold_i ? hold_trig_n_i : 1'b1;

assign release_pulse = hold_flag & ref_edge & release_ok;

// entry shows in the same cycle; the flag holds it afterwards
assign charge_pump_hiz_o = hold_flag | entry;

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        trig_prev <= `PHC_RST_TRIG;
    end else begin
        trig_prev <= hold_trig_n_i;
    end
end

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        hold_flag <= `PHC_RST_HOLD;
    end else if (!hold_en) begin
        hold_flag <= 1'b0;
    end else if (entry) begin
        hold_flag <= 1'b1;
    end else if (release_pulse) begin
        hold_flag <= 1'b0;
    end
end

// feedback main counter reset rides the release; prescaler is never touched
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        main_cnt_reset_o <= 1'b0;
    end else begin
        main_cnt_reset_o <= hold_en & release_pulse;
    end
end

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        holdover_active_o <= 1'b0;
    end else begin
        holdover_active_o <= hold_en & (entry | (hold_flag & ~release_pulse));
    end
end

// a chattering pin would retrigger forever; re-arm only once relocked
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        armed <= `PHC_RST_ARMED;
    end else if (entry | hold_flag) begin
        armed <= 1'b0;
    end else if (dld_locked & lock_level) begin
        armed <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// lock indicator pin drive

reg next_ld_pin;
reg next_ld_oe;
reg next_src;
reg next_short;

always @* begin
    next_ld_pin = 1'b0;
    next_ld_oe = 1'b1;
    next_src = 1'b0;
    next_short = 1'b0;
    if (ld_out_sel_i == `PHC_LDSEL_CSRC) begin
        // current source charges the cap; any false discharges it
        next_ld_oe = 1'b0;
        next_src = dld_locked;
        next_short = ~dld_locked;
    end else if (ld_out_sel_i == `PHC_LDSEL_DLD_HI) begin
        next_ld_pin = dld_locked;
    end else if (ld_out_sel_i == `PHC_LDSEL_DLD_LO) begin
        next_ld_pin = ~dld_locked;
    end
end

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        ld_pin_o <= 1'b0;
        ld_pin_oe_o <= 1'b0;
        ld_src_en_o <= 1'b0;
        ld_short_o <= 1'b0;
    end else begin
        ld_pin_o <= next_ld_pin;
        ld_pin_oe_o <= next_ld_oe;
        ld_src_en_o <= next_src;
        ld_short_o <= next_short;
    end
end

////////////////////////////////////////////////////////////////////////
// analog settings and reference buffers

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        window_high_o <= 1'b0;
        first_reference_buf_en_o <= 1'b0;
        second_reference_buf_en_o <= 1'b0;
    end else begin
        window_high_o <= ~ld_window_i;
        first_reference_buf_en_o <= ref_buf_sel_i[0];
        second_reference_buf_en_o <= ref_buf_sel_i[1];
    end
end

////////////////////////////////////////////////////////////////////////
// monitor and status pin routing

phc_stat_mux #(
    .SEL_W(`PHC_MON_W),
    .CODE_DLD_HI(`PHC_MON_DLD_HI),
    .CODE_DLD_LO(`PHC_MON_DLD_LO),
    .CODE_CMP_HI(`PHC_MON_CMP_HI),
    .CODE_CMP_LO(`PHC_MON_CMP_LO),
    .CODE_FIRST_REFERENCE_LO(`PHC_MON_FIRST_REFERENCE_LO)
) u_reference_monitor_pin (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sel_i(reference_monitor_pin_sel_i[4:0]),
    .dld_i(dld_locked),
    .cmp_i(ld_cmp_i),
    .first_reference_ok_i(first_reference_ok_i),
    .pin_o(reference_monitor_pin_pin_o)
);

phc_stat_mux #(
    .SEL_W(`PHC_STS_W),
    .CODE_DLD_HI(`PHC_STS_DLD_HI),
    .CODE_DLD_LO(`PHC_STS_DLD_LO),
    .CODE_CMP_HI(`PHC_STS_CMP_HI),
    .CODE_CMP_LO(`PHC_STS_CMP_LO),
    .CODE_FIRST_REFERENCE_LO(`PHC_STS_FIRST_REFERENCE_LO)
) u_status (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sel_i(status_sel_i),
    .dld_i(dld_locked),
    .cmp_i(ld_cmp_i),
    .first_reference_ok_i(first_reference_ok_i),
    .pin_o(status_pin_o)
);

endmodule

// ==== dv/phc_ref_src.sv ====
// reference source model: phase detector edges and phase error class
`timescale 1ns/1ps

module phc_ref_src (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // control
    input wire run_i,
    input wire good_i,
    // phase detector side
    output reg first_reference_edge_o,
    output reg second_reference_edge_o,
    output reg err_below_lock_o,
    output reg err_above_unlock_o
);
    reg [1:0] cnt;
    // no reference means no edges at all: the clock stands still
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 2'h0;
            first_reference_edge_o <= 1'b0;
            second_reference_edge_o <= 1'b0;
            err_below_lock_o <= 1'b0;
            err_above_unlock_o <= 1'b1;
        end else begin
            cnt <= run_i ? cnt + 2'h1 : cnt;
            first_reference_edge_o <= run_i && cnt == 2'h0;
            second_reference_edge_o <= run_i && cnt == 2'h2;
            // error class only valid with an edge, garbage otherwise
            if (run_i && !cnt[0]) begin
                err_below_lock_o <= good_i;
                err_above_unlock_o <= !good_i;
            end else begin
                err_below_lock_o <= !err_below_lock_o;
                err_above_unlock_o <= !err_above_unlock_o;
            end
        end
    end
endmodule

// ==== dv/phc_top_sva.sv ====
// assertion checker for the pll holdover controller ports
`timescale 1ns/1ps

module phc_top_sva #(
    parameter CNT_W = 8
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // controls
    input wire hold_en0_i,
    input wire hold_en2_i,
    input wire ext_hold_i,
    input wire ld_cmp_en_i,
    input wire ld_window_i,
    input wire dld_disable_i,
    input wire [5:0] ld_out_sel_i,
    input wire ref_sel_i,
    input wire hold_trig_n_i,
    input wire first_reference_edge_i,
    input wire second_reference_edge_i,
    // observed outputs
    input wire charge_pump_hiz_o,
    input wire main_cnt_reset_o,
    input wire dld_locked_o,
    input wire window_high_o,
    input wire ld_src_en_o,
    input wire ld_short_o,
    input wire ld_pin_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire en = hold_en0_i && hold_en2_i;
    wire sel_edge = ref_sel_i ? second_reference_edge_i : first_reference_edge_i;

    off_no_hiz_a: assert property (!en [*2] |-> !charge_pump_hiz_o)
        else $error("hiz while holdover disabled");
    man_fall_a: assert property (en && ext_hold_i && $fell(hold_trig_n_i) |-> charge_pump_hiz_o)
        else $error("trigger fall did not freeze");
    man_level_a: assert property (en && ext_hold_i && !hold_trig_n_i &&
        $past(!hold_trig_n_i) && $past(!charge_pump_hiz_o) |-> !charge_pump_hiz_o)
        else $error("low level froze the charge pump");
    rel_edge_a: assert property ($fell(charge_pump_hiz_o) && en && $past(en)
        |-> $past(sel_edge))
        else $error("release without reference edge");
    rel_pulse_a: assert property (main_cnt_reset_o |-> $fell(charge_pump_hiz_o) ##1
        !main_cnt_reset_o)
        else $error("counter reset not tied to release");
    cmp_off_a: assert property (en && !ext_hold_i && !ld_cmp_en_i &&
        $past(!charge_pump_hiz_o) |-> !charge_pump_hiz_o)
        else $error("auto entry with comparator off");
    dld_off_a: assert property (dld_disable_i [*2] |-> !dld_locked_o)
        else $error("locked while indicator disabled");
    csrc_drive_a: assert property ((ld_out_sel_i == 6'h04) [*2] |->
        ld_src_en_o != ld_short_o && !ld_pin_oe_o)
        else $error("current source drive inconsistent");
    window_a: assert property ($past(!rst_i) |-> window_high_o == !$past(ld_window_i))
        else $error("window range wrong");
endmodule

bind phc_top phc_top_sva #(.CNT_W(CNT_W)) u_sva (.mclk_i, .rst_i, .hold_en0_i, .hold_en2_i,
    .ext_hold_i, .ld_cmp_en_i, .ld_window_i, .dld_disable_i, .ld_out_sel_i, .ref_sel_i,
    .hold_trig_n_i, .first_reference_edge_i, .second_reference_edge_i, .charge_pump_hiz_o, .main_cnt_reset_o,
    .dld_locked_o, .window_high_o, .ld_src_en_o, .ld_short_o, .ld_pin_oe_o);

// ==== dv/tb_phc_top.sv ====
// self-checking bench for the pll holdover controller
`timescale 1ns/1ps
`define CMP(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: output %0d mismatch", $time, n[4:1]); end end

module tb_phc_top;
    reg mclk_i = 0, rst_i = 1, hold_en0_i = 0, hold_en2_i = 0, ext_hold_i = 1, ld_cmp_en_i = 1;
    reg [1:0] ld_cnt_sel_i = 2'h0, ref_buf_sel_i = 2'h3;
    reg ld_window_i = 0, dld_disable_i = 0, ref_sel_i = 0, hold_trig_n_i = 1;
    reg [5:0] ld_out_sel_i = 6'h04, status_sel_i = 6'h0c;
    reg [7:0] reference_monitor_pin_sel_i = 8'hf7;
    reg first_reference_ok_i = 1, ld_cmp_i = 1, run = 0, good = 1;
    wire r1, r2, eb, ea, hiz, mcr, act, pin, oe, src, sh, win, b1, b2, lk, rm, st;
    wire [12:0] obs = {oe, pin, hiz, mcr, act, lk, rm, st, win, b1, b2, src, sh};
    logic [4:0] q[$];
    logic [4:0] n;
    logic [31:0] seed = 32'h43b69ffc;
    int fails = 0, tests_run = 0;

    phc_ref_src u_src (.mclk_i(mclk_i), .rst_i(rst_i), .run_i(run), .good_i(good),
        .first_reference_edge_o(r1), .second_reference_edge_o(r2), .err_below_lock_o(eb), .err_above_unlock_o(ea));
    phc_top #(.CNT_W(8)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .hold_en0_i(hold_en0_i),
        .hold_en2_i(hold_en2_i), .ext_hold_i(ext_hold_i), .ld_cmp_en_i(ld_cmp_en_i),
        .ld_cnt_sel_i(ld_cnt_sel_i), .ld_window_i(ld_window_i), .dld_disable_i(dld_disable_i),
        .ld_out_sel_i(ld_out_sel_i), .reference_monitor_pin_sel_i(reference_monitor_pin_sel_i), .status_sel_i(status_sel_i),
        .ref_buf_sel_i(ref_buf_sel_i), .ref_sel_i(ref_sel_i), .hold_trig_n_i(hold_trig_n_i),
        .first_reference_edge_i(r1), .second_reference_edge_i(r2), .err_below_lock_i(eb), .err_above_unlock_i(ea),
        .first_reference_ok_i(first_reference_ok_i), .ld_cmp_i(ld_cmp_i), .charge_pump_hiz_o(hiz),
        .main_cnt_reset_o(mcr), .holdover_active_o(act), .ld_pin_o(pin), .ld_pin_oe_o(oe),
        .ld_src_en_o(src), .ld_short_o(sh), .window_high_o(win), .first_reference_buf_en_o(b1),
        .second_reference_buf_en_o(b2), .dld_locked_o(lk), .reference_monitor_pin_pin_o(rm), .status_pin_o(st));

    initial forever #25 mclk_i = !mclk_i;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic step(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    // notes land in the queue; the monitor settles them at the next falling edge
    task automatic note(input int i, input logic v);
        q.push_back({i[3:0], v});
    endtask
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_edges(input int k);
        int t;
        repeat (k) begin
            t = 0;
            step(1);
            while ((ref_sel_i ? r2 : r1) !== 1'b1) begin
                step(1);
                t++;
                if (t > 20) begin
                    fails++;
                    wrap_up();
                end
            end
        end
    endtask

    always @(negedge mclk_i)
        while (q.size() > 0) begin
            n = q.pop_front();
            `CMP(obs[n[4:1]], n[0])
        end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        step(10);
        rst_i = 0;
        step(2);
        note(4, 1);
        note(3, 1);
        note(0, 1);
        note(12, 0);
        ld_window_i = 1;
        ref_buf_sel_i = 2'h1;
        step(2);
        note(4, 0);
        note(2, 0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            first_reference_ok_i = seed[0];
            ld_cmp_i = seed[1];
            status_sel_i = i[0] ? 6'h2c : 6'h0c;
            step(2);
            note(6, !seed[0]);
            note(5, seed[1] ^ i[0]);
        end
        ld_cmp_i = 1;
        run = 1;
        wait_edges(4);
        step(2);
        note(7, 0);
        wait_edges(1);
        step(2);
        note(7, 1);
        note(1, 1);
        good = 0;
        wait_edges(1);
        step(2);
        note(7, 0);
        good = 1;
        wait_edges(5);
        step(2);
        // enables only after calibration would be done, current source with manual trigger mode
        hold_en0_i = 1;
        hold_en2_i = 0;
        hold_trig_n_i = 0;
        note(10, 0);
        step(3);
        note(10, 0);
        hold_trig_n_i = 1;
        hold_en2_i = 1;
        run = 0;
        ref_sel_i = 1;
        step(2);
        // outputs assumed set to ignore the trigger after this first event
        hold_trig_n_i = 0;
        note(10, 1);
        step(1);
        note(8, 1);
        step(2);
        hold_trig_n_i = 1;
        step(8);
        note(10, 1);
        run = 1;
        wait_edges(1);
        step(1);
        note(10, 0);
        note(9, 1);
        step(1);
        note(9, 0);
        wait_edges(6);
        ext_hold_i = 0;
        run = 0;
        step(1);
        ld_cmp_i = 0;
        note(10, 1);
        step(6);
        note(10, 1);
        run = 1;
        wait_edges(1);
        step(1);
        note(9, 1);
        step(3);
        note(10, 0);
        ld_cmp_i = 1;
        step(2);
        ld_cmp_i = 0;
        note(10, 1);
        wait_edges(1);
        ld_cmp_en_i = 0;
        ld_cmp_i = 1;
        step(3);
        ld_cmp_i = 0;
        step(2);
        note(10, 0);
        ld_cmp_en_i = 1;
        dld_disable_i = 1;
        note(10, 0);
        step(3);
        note(7, 0);
        // holdover off before any vco calibration request
        hold_en0_i = 0;
        ld_out_sel_i = 6'h02;
        step(2);
        note(10, 0);
        note(11, 1);
        note(12, 1);
        step(2);
        wrap_up();
    end
endmodule
